// ### eeprom_bus_host.sv
// Behavioural two-wire bus host that makes the clock and every Start and Stop.
// Assumes a pull-up on the data wire: it reads high unless some party pulls it low.
`timescale 1ns/1ps
`default_nettype none
module eeprom_bus_host (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull
);
  // The clock stands high between frames, so the bus is idle before each Start except a repeated one.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic quarter();
    repeat (4) @(negedge clk);
  endtask

  // Data moves only in the middle of the low half, giving the client time to let go.
  task automatic bit_io(input logic tx, output logic rx);
    quarter();
    sda_pull = ~tx;
    quarter();
    scl = 1'b1;
    quarter();
    rx = sda_wire;
    quarter();
    scl = 1'b0;
  endtask

  task automatic start_cond();
    quarter();
    sda_pull = 1'b0;
    quarter();
    scl = 1'b1;
    quarter();
    sda_pull = 1'b1;
    quarter();
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    quarter();
    sda_pull = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    sda_pull = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  // Sending all ones leaves the line to the device; nine is the host's own ninth bit.
  task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], b);
      rx[i] = b;
    end
    bit_io(nine, b);
    ack = ~b;
  endtask
endmodule // eeprom_bus_host
`default_nettype wire

// ### eeprom_client_pkg.sv
// Shared constants, types and state encodings for the two-wire EEPROM bus client.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
`default_nettype none
package eeprom_client_pkg;
  // Arbitrary neutral value; the real type code is set per product.
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'h5;
  localparam int ADDR_W = 13;
  localparam int WR_W = ADDR_W + 8;
  localparam logic [5:0] PAGE_BYTES = 6'h20;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;
  localparam logic [1:0] PROT_TOP = 2'h3;
  localparam int TWC_MS = 5;
  localparam int CLK_MHZ = 200;
  localparam int TWC_CYCLES = TWC_MS * CLK_MHZ * 1000;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h3,
    ST_TX = 3'h2,
    ST_RACK = 3'h6,
    ST_IGNORE = 3'h7
  } state_t;
  typedef enum logic [1:0] {
    K_CTRL = 2'h0,
    K_ADDR_HI = 2'h1,
    K_ADDR_LO = 2'h3,
    K_DATA = 2'h2
  } kind_t;
endpackage
`default_nettype wire

// ### line_sync.sv
// Two-stage synchroniser with a third stage kept for edge detection.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module line_sync #(parameter int W = 2) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic [W-1:0] dprev
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // Reset to all ones so an idle bus does not look like an edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign dout = sync_q;
  assign dprev = prev_q;
endmodule // line_sync
`default_nettype wire

// ### pair_buffer.sv
// Small shift-register buffer with valid/ready on both sides; outputs come from flops.
// Assumes DEPTH is at least two.
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(parameter int WIDTH = 21, parameter int DEPTH = 2) (
  input wire logic clk,
  input wire logic sys_rst,
  stream_if.snk in_s,
  stream_if.src out_s
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] nxt [DEPTH];
  logic [DEPTH-1:0] full_q;
  logic [DEPTH-1:0] kept;
  logic [DEPTH-1:0] slot;
  logic pop;
  logic push;

  assign pop = full_q[0] & out_s.ready;
  assign push = in_s.valid & in_s.ready;
  assign in_s.ready = ~full_q[DEPTH-1];
  assign out_s.valid = full_q[0];
  assign out_s.data = mem_q[0];
  assign kept = pop ? {1'b0, full_q[DEPTH-1:1]} : full_q;
  // A new word lands in the first free slot after the shift.
  assign slot = {DEPTH{push}} & ~kept & {kept[DEPTH-2:0], 1'b1};

  always_comb begin
    for (int i = 0; i < DEPTH - 1; i++) begin
      nxt[i] = mem_q[i+1];
    end
    nxt[DEPTH-1] = mem_q[DEPTH-1];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      full_q <= '0;
    end else begin
      full_q <= kept | slot;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (sys_rst) begin
        mem_q[i] <= '0;
      end else if (slot[i]) begin
        mem_q[i] <= in_s.data;
      end else if (pop) begin
        mem_q[i] <= nxt[i];
      end
    end
  end
endmodule // pair_buffer
`default_nettype wire

// ### serial_eeprom_bus_client.sv
// Two-wire bus client front end: Start/Stop detection, control byte decode,
// word address capture, page buffer, acknowledge and write-protect handling.
// Assumes the memory array sits outside: it answers reads one clock after the
// address changes and takes write words through a valid/ready port.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_client #(
  parameter int TWC_COUNT = eeprom_client_pkg::TWC_CYCLES,
  // Arbitrary neutral default for the device-type code.
  parameter logic [3:0] TYPE_CODE = eeprom_client_pkg::DEVICE_TYPE_CODE
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output wire logic sda_out,
  output wire logic sda_oe,
  input wire logic chip_select_pin_low,
  input wire logic chip_select_pin_mid,
  input wire logic chip_select_pin_high,
  input wire logic write_protect_in,
  output wire eeprom_client_pkg::addr_t mem_rd_addr,
  input wire eeprom_client_pkg::byte_t mem_rd_data,
  output wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output wire eeprom_client_pkg::addr_t mem_wr_addr,
  output wire eeprom_client_pkg::byte_t mem_wr_data,
  output wire logic write_busy
);
  import eeprom_client_pkg::*;

  localparam int TW = $clog2(TWC_COUNT + 1);
  localparam logic [TW-1:0] TWC_LAST = TW'(TWC_COUNT - 1);

  logic [1:0] bus_s;
  logic [1:0] bus_p;
  logic [3:0] pin_s;
  logic scl_s, sda_s, scl_p, sda_p;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic byte_end, ctrl_match, ack_now, data_take, wp_block;

  state_t state_q;
  kind_t kind_q;
  logic [3:0] bit_cnt_q;
  byte_t rx_q;
  byte_t tx_q;
  logic rw_q;
  logic host_ack_q;
  logic sda_oe_q;
  addr_t ptr_q;
  logic [4:0] start_off_q;
  logic [5:0] nbytes_q;
  logic pend_q;
  byte_t page_buf_q [32];

  logic busy_q;
  logic streaming_q;
  logic [4:0] wr_first_q;
  logic [5:0] wr_idx_q;
  logic [5:0] wr_n_q;
  logic [7:0] wr_page_q;
  logic [TW-1:0] wc_timer_q;
  logic [4:0] wr_slot;

  stream_if #(.W(WR_W)) wr_in ();
  stream_if #(.W(WR_W)) wr_out ();

  // Sampling both lines through synchronisers keeps Start/Stop detection glitch-free.
  line_sync #(.W(2)) bus_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({scl_in, sda_in}),
    .dout(bus_s),
    .dprev(bus_p)
  );

  line_sync #(.W(4)) pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({write_protect_in, chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low}),
    .dout(pin_s),
    .dprev()
  );

  pair_buffer #(.WIDTH(WR_W), .DEPTH(2)) wr_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_s(wr_in.snk),
    .out_s(wr_out.src)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];
  assign scl_p = bus_p[1];
  assign sda_p = bus_p[0];
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;

  assign byte_end = scl_fall && (state_q == ST_RX) && (bit_cnt_q == BYTE_BITS);
  assign ctrl_match = (rx_q[7:4] == TYPE_CODE) && (rx_q[3:1] == pin_s[2:0]);
  // A busy device stays silent even to its own control byte.
  assign ack_now = byte_end && ((kind_q != K_CTRL) || (ctrl_match && !busy_q));
  assign data_take = ack_now && (kind_q == K_DATA);
  assign wp_block = pin_s[3] && (ptr_q[12:11] == PROT_TOP);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      kind_q <= K_CTRL;
      bit_cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      rw_q <= 1'b0;
      host_ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ptr_q <= '0;
      start_off_q <= '0;
      nbytes_q <= '0;
      pend_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= ST_RX;
      kind_q <= K_CTRL;
      bit_cnt_q <= '0;
      sda_oe_q <= 1'b0;
      nbytes_q <= '0;
      pend_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            rx_q <= {rx_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_end) begin
            bit_cnt_q <= '0;
            if (ack_now) begin
              state_q <= ST_ACK;
              sda_oe_q <= 1'b1;
              case (kind_q)
                K_CTRL: begin
                  rw_q <= rx_q[0];
                  kind_q <= K_ADDR_HI;
                end
                K_ADDR_HI: begin
                  ptr_q[12:8] <= rx_q[4:0];
                  kind_q <= K_ADDR_LO;
                end
                K_ADDR_LO: begin
                  ptr_q[7:0] <= rx_q;
                  start_off_q <= rx_q[4:0];
                  kind_q <= K_DATA;
                end
                default: begin
                  ptr_q[4:0] <= ptr_q[4:0] + 5'h1;
                  nbytes_q <= (nbytes_q == PAGE_BYTES) ? nbytes_q : nbytes_q + 6'h1;
                  pend_q <= 1'b1;
                end
              endcase
            end else begin
              state_q <= ST_IGNORE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw_q && kind_q == K_ADDR_HI) begin
              tx_q <= mem_rd_data;
              sda_oe_q <= ~mem_rd_data[7];
              bit_cnt_q <= '0;
              state_q <= ST_TX;
            end else begin
              sda_oe_q <= 1'b0;
              state_q <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == TX_LAST_BIT) begin
              sda_oe_q <= 1'b0;
              state_q <= ST_RACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            host_ack_q <= ~sda_s;
            ptr_q <= ptr_q + 13'h1;
          end else if (scl_fall) begin
            if (host_ack_q) begin
              tx_q <= mem_rd_data;
              sda_oe_q <= ~mem_rd_data[7];
              bit_cnt_q <= '0;
              state_q <= ST_TX;
            end else begin
              state_q <= ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Slots wrap inside the page, so an overlong write keeps only the newest bytes.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 32; i++) begin
      if (sys_rst) begin
        page_buf_q[i] <= '0;
      end else if (data_take && ptr_q[4:0] == 5'(i)) begin
        page_buf_q[i] <= rx_q;
      end
    end
  end

  // Write protect is looked at only on the Stop edge; later toggles change nothing.
  // A stalled array can stretch the cycle past its budget, so mem_wr_ready must keep up.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      streaming_q <= 1'b0;
      wr_first_q <= '0;
      wr_idx_q <= '0;
      wr_n_q <= '0;
      wr_page_q <= '0;
      wc_timer_q <= '0;
    end else if (stop_ev && pend_q && !busy_q) begin
      if (!wp_block) begin
        busy_q <= 1'b1;
        streaming_q <= 1'b1;
        wr_first_q <= (nbytes_q == PAGE_BYTES) ? ptr_q[4:0] : start_off_q;
        wr_idx_q <= '0;
        wr_n_q <= nbytes_q;
        wr_page_q <= ptr_q[12:5];
        wc_timer_q <= '0;
      end
    end else if (busy_q) begin
      if (wc_timer_q != TWC_LAST) begin
        wc_timer_q <= wc_timer_q + TW'(1);
      end
      if (streaming_q && wr_in.ready) begin
        wr_idx_q <= wr_idx_q + 6'h1;
        if (wr_idx_q == wr_n_q - 6'h1) begin
          streaming_q <= 1'b0;
        end
      end
      if (wc_timer_q == TWC_LAST && !streaming_q && !wr_out.valid) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign wr_slot = wr_first_q + wr_idx_q[4:0];
  assign wr_in.valid = streaming_q;
  assign wr_in.data = {wr_page_q, wr_slot, page_buf_q[wr_slot]};
  assign wr_out.ready = mem_wr_ready;

  // The pin is open drain, so the driven level is always low.
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_q;
  assign mem_rd_addr = ptr_q;
  assign mem_wr_valid = wr_out.valid;
  assign mem_wr_addr = wr_out.data[WR_W-1:8];
  assign mem_wr_data = wr_out.data[7:0];
  assign write_busy = busy_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  start_resets_rx_a: assert property (start_ev |=> state_q == ST_RX && bit_cnt_q == 4'h0)
    else $error("Start did not restart byte reception");
  stop_goes_idle_a: assert property (stop_ev |=> state_q == ST_IDLE && !sda_oe_q)
    else $error("Stop did not release the bus");
  drive_on_fall_a: assert property ($rose(sda_oe_q) |-> $past(scl_fall))
    else $error("Data line driven outside clock low");
  no_ack_busy_a: assert property (busy_q |-> state_q != ST_ACK)
    else $error("Acknowledge while programming");
  ack_held_low_a: assert property (state_q == ST_ACK && !scl_fall |=> sda_oe_q)
    else $error("Acknowledge released early");
  ctrl_match_ack_a: assert property (byte_end && kind_q == K_CTRL
      |=> (state_q == ST_ACK) == $past(ctrl_match && !busy_q))
    else $error("Control byte acknowledge mismatch");
  nack_release_a: assert property (state_q == ST_RACK && scl_fall && !host_ack_q
      |=> state_q == ST_IGNORE && !sda_oe_q)
    else $error("Line not released after host nack");
  page_wrap_a: assert property (data_take |=> ptr_q[12:5] == $past(ptr_q[12:5])
      && ptr_q[4:0] == $past(ptr_q[4:0]) + 5'h1)
    else $error("Page pointer left its page");
  protect_block_a: assert property (stop_ev && pend_q && !busy_q && wp_block
      |=> !busy_q)
    else $error("Protected write started a cycle");
  cycle_bound_a: assert property ($fell(busy_q) |-> $past(wc_timer_q) == TWC_LAST)
    else $error("Write cycle length wrong");
endmodule // serial_eeprom_bus_client
`default_nettype wire

// ### stream_if.sv
// Valid/ready stream carrying address and data words between the client's modules.
// Assumes source and sink share one clock.
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 21);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// ### test_serial_eeprom_bus_client.sv
// Self-checking bench: a host model on the wire and a stalling array model behind the block.
// Assumes the design package and modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
  $display("FAIL %s expected %0h seen %0h", what, exp, got); fails++; end end
module test_serial_eeprom_bus_client;
  import eeprom_client_pkg::*;
  localparam int TWC = 200;
  // Not a mirror image, so swapped high and low strap pins are caught.
  localparam logic [2:0] STRAP = 3'h6;
  localparam byte_t CTRL_W = {DEVICE_TYPE_CODE, STRAP, 1'b0};
  localparam byte_t CTRL_R = {DEVICE_TYPE_CODE, STRAP, 1'b1};
  logic clk, sys_rst, scl, sda_pull, sda_out, sda_oe, cs_low, cs_mid, cs_high, wp;
  logic mem_wr_valid, mem_wr_ready, write_busy;
  wire logic sda_wire;
  addr_t mem_rd_addr, mem_wr_addr;
  byte_t mem_rd_data, mem_wr_data;
  byte_t mem [8192];
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  logic timed_out = 1'b0;

  // Open drain with pull-up: low whenever either party pulls.
  assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

  eeprom_bus_host host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

  serial_eeprom_bus_client #(.TWC_COUNT(TWC)) DUT (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_pin_low(cs_low), .chip_select_pin_mid(cs_mid),
    .chip_select_pin_high(cs_high), .write_protect_in(wp), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .write_busy(write_busy));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic byte_t seed_val(input int a);
    return 8'(a * 7);
  endfunction

  // The array accepts one word in eight cycles, so the two-entry buffer fills and waits.
  always @(negedge clk) begin
    mem_rd_data <= mem[mem_rd_addr];
    mem_wr_ready <= (cycles % 8 == 0);
  end

  // The array is seeded during reset so that this process alone writes it.
  always @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8192; i++) mem[i] <= seed_val(i);
    end else if (mem_wr_valid && mem_wr_ready) begin
      mem[mem_wr_addr] <= mem_wr_data;
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      timed_out = 1'b1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails + int'(timed_out));
    if (fails == 0 && !timed_out && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic send(input byte_t b, input logic exp_ack);
    byte_t rx;
    logic ack;
    host.xfer(b, 1'b1, rx, ack);
    `CHK("ack", exp_ack, ack)
  endtask

  task automatic write_one(input addr_t a, input byte_t d);
    host.start_cond();
    send(CTRL_W, 1'b1);
    send({3'h0, a[12:8]}, 1'b1);
    send(a[7:0], 1'b1);
    send(d, 1'b1);
    host.stop_cond();
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    `CHK("busy", 1'b0, write_busy)
  endtask

  initial begin
    byte_t rx;
    logic ack;
    byte_t exp [32];
    sys_rst = 1'b1;
    wp = 1'b0;
    {cs_high, cs_mid, cs_low} = STRAP;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int c = 0; c < 9; c++) begin
      host.start_cond();
      if (c < 8) begin
        send({DEVICE_TYPE_CODE, 3'(c), 1'b0}, 1'(c == STRAP));
      end else begin
        send({DEVICE_TYPE_CODE ^ 4'h3, STRAP, 1'b0}, 1'b0);
      end
      host.stop_cond();
    end
    // A part without strap pins sees them all low, so the host sends zeros.
    {cs_high, cs_mid, cs_low} = 3'h0;
    host.start_cond();
    send({DEVICE_TYPE_CODE, 3'h0, 1'b0}, 1'b1);
    host.stop_cond();
    {cs_high, cs_mid, cs_low} = STRAP;
    $display("test addressing done");
    // Page write of 34 bytes from offset 5; the top three address bits are junk.
    host.start_cond();
    send(CTRL_W, 1'b1);
    send(8'hE1, 1'b1);
    send(8'h05, 1'b1);
    for (int i = 0; i < 34; i++) begin
      send(8'(8'h80 + i), 1'b1);
      exp[(5 + i) % 32] = 8'(8'h80 + i);
    end
    host.stop_cond();
    `CHK("busy after stop", 1'b1, write_busy)
    host.start_cond();
    send(CTRL_W, 1'b0);
    host.stop_cond();
    wait_idle();
    for (int o = 0; o < 32; o++) `CHK("page", exp[o], mem[13'h0100 + o])
    `CHK("next page", seed_val(13'h0120), mem[13'h0120])
    $display("test page write done");
    wp = 1'b1;
    write_one(13'h1800, 8'h3C);
    `CHK("protected busy", 1'b0, write_busy)
    wp = 1'b0;
    write_one(13'h1810, 8'hA5);
    wp = 1'b1;
    wait_idle();
    `CHK("protected cell", seed_val(13'h1800), mem[13'h1800])
    `CHK("late protect", 8'hA5, mem[13'h1810])
    $display("test protection done");
    host.start_cond();
    send(CTRL_W, 1'b1);
    send(8'hFF, 1'b1);
    send(8'hFF, 1'b1);
    host.start_cond();
    send(CTRL_R, 1'b1);
    host.xfer(8'hFF, 1'b0, rx, ack);
    `CHK("read top", seed_val(13'h1FFF), rx)
    host.xfer(8'hFF, 1'b1, rx, ack);
    `CHK("read wrap", seed_val(0), rx)
    repeat (6) @(negedge clk);
    `CHK("released", 1'b0, sda_oe)
    host.stop_cond();
    $display("test read done");
    report_and_stop();
  end
endmodule // test_serial_eeprom_bus_client
`default_nettype wire
